// *** rtl/ext_irq_ctrl.sv ***
// external interrupt mode, priority and request flag controller
module ext_irq_ctrl (
  input wire logic mclk,
  input wire logic srst,
  input wire ext_irq_pkg::bus_req_type bus,
  output logic [7:0] rdata,
  input wire logic nmi_pin,
  input wire logic watchdog_interrupt,
  input wire logic [ext_irq_pkg::num_ext-1:0] ext_pins,
  input wire logic [ext_irq_pkg::num_wake-1:0] wake_pins,
  input wire logic irq_accept,
  output ext_irq_pkg::irq_req_type irq_req,
  output logic irq_out
);

  localparam int ns = ext_irq_pkg::num_src;

  logic [7:0] mode_q, mode_d;
  logic [7:0] wmode_q, wmode_d;
  logic [7:0] wpol_q, wpol_d;
  logic [7:0] tmode_q, tmode_d;
  logic [2:0] prio_q [ns];
  logic [2:0] prio_d [ns];
  logic [ns-1:0] pend_q, pend_d;
  logic [3:0] stat_q, stat_d;
  logic [3:0] ien_q, ien_d;
  logic [7:0] rdata_q, rdata_d;
  ext_irq_pkg::irq_req_type req_q, req_d;
  logic [ns-1:0] hit;
  ext_irq_pkg::edge_sel_type sel [ns];
  logic [ns-1:0] pins;
  logic [ns-1:0] clr_hit;
  logic [3:0] ev;

  // ===========================================
  // pin collection and per source sensing choice
  always_comb begin
    pins = {wake_pins, ext_pins, watchdog_interrupt, nmi_pin};
    for (int i = 0; i < ns; i++) begin
      sel[i] = ext_irq_pkg::edge_rise;
    end
    sel[ext_irq_pkg::src_nmi] = mode_q[ext_irq_pkg::nmi_both_edges_bit] ?
      ext_irq_pkg::edge_both : ext_irq_pkg::edge_fall;
    sel[ext_irq_pkg::src_first_external_interrupt] = mode_q[ext_irq_pkg::first_external_interrupt_level_mode_bit] ?
      ext_irq_pkg::edge_high : ext_irq_pkg::edge_rise;
    sel[ext_irq_pkg::src_external_interrupt_five] = (tmode_q[1:0] == ext_irq_pkg::capture_falling) ?
      ext_irq_pkg::edge_fall : ext_irq_pkg::edge_rise;
    sel[ext_irq_pkg::src_external_interrupt_seven] = (tmode_q[5:4] == ext_irq_pkg::capture_falling) ?
      ext_irq_pkg::edge_fall : ext_irq_pkg::edge_rise;
    for (int n = 0; n < ext_irq_pkg::num_wake; n++) begin
      if (!wmode_q[n]) begin
        sel[ext_irq_pkg::src_wake0 + n] = ext_irq_pkg::edge_both;
      end else begin
        sel[ext_irq_pkg::src_wake0 + n] = wpol_q[n] ?
          ext_irq_pkg::edge_rise : ext_irq_pkg::edge_fall;
      end
    end
  end

  // ===========================================
  // one detector per source
  for (genvar g = 0; g < ns; g++) begin : g_det
    edge_detect u_det (
      .mclk(mclk),
      .srst(srst),
      .pin(pins[g]),
      .sel(sel[g]),
      .hit(hit[g])
    );
  end

  // ===========================================
  // clear register decode
  always_comb begin
    for (int i = 0; i < ns; i++) begin
      clr_hit[i] = bus.wr && bus.addr == ext_irq_pkg::interrupt_clear_register_addr &&
        bus.wdata == ext_irq_pkg::vector_base + 8'(i);
    end
  end

  // ===========================================
  // configuration registers
  always_comb begin
    mode_d = mode_q;
    wmode_d = wmode_q;
    wpol_d = wpol_q;
    tmode_d = tmode_q;
    ien_d = ien_q;
    for (int i = 0; i < ns; i++) begin
      prio_d[i] = prio_q[i];
    end
    if (bus.wr) begin
      case (bus.addr)
        ext_irq_pkg::input_mode_register_addr: mode_d = {6'h00, bus.wdata[1:0]};
        ext_irq_pkg::wake_mode_register_addr: wmode_d = bus.wdata;
        ext_irq_pkg::wake_polarity_register_addr: wpol_d = bus.wdata;
        ext_irq_pkg::timer_mode_addr: tmode_d = bus.wdata;
        ext_irq_pkg::irq_enable_addr: ien_d = bus.wdata[3:0];
        default: begin
          for (int i = 0; i < ns; i++) begin
            if (bus.addr == ext_irq_pkg::priority_base_addr + 8'(i)) begin
              prio_d[i] = bus.wdata[2:0];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_q <= ext_irq_pkg::reg_reset;
      wmode_q <= ext_irq_pkg::reg_reset;
      wpol_q <= ext_irq_pkg::reg_reset;
      tmode_q <= ext_irq_pkg::reg_reset;
      ien_q <= 4'h0;
      for (int i = 0; i < ns; i++) begin
        prio_q[i] <= 3'h0;
      end
    end else begin
      mode_q <= mode_d;
      wmode_q <= wmode_d;
      wpol_q <= wpol_d;
      tmode_q <= tmode_d;
      ien_q <= ien_d;
      for (int i = 0; i < ns; i++) begin
        prio_q[i] <= prio_d[i];
      end
    end
  end

  // ===========================================
  // pending flags and request arbitration
  always_comb begin
    logic [2:0] best;
    best = 3'h0;
    req_d = '0;
    pend_d = pend_q;
    for (int i = 0; i < ns; i++) begin
      if (clr_hit[i] || (irq_accept && req_q.valid && req_q.source == 5'(i))) begin
        pend_d[i] = 1'b0;
      end
      if (hit[i]) begin
        pend_d[i] = 1'b1;
      end
    end
    for (int i = 0; i < ns; i++) begin
      if (pend_q[i] && prio_q[i] != ext_irq_pkg::prio_off_lo &&
          prio_q[i] != ext_irq_pkg::prio_off_hi && prio_q[i] > best) begin
        best = prio_q[i];
        req_d.valid = 1'b1;
        req_d.source = 5'(i);
        req_d.level = prio_q[i];
      end
    end
    if (irq_accept && req_q.valid) begin
      req_d = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pend_q <= '0;
      req_q <= '0;
    end else begin
      pend_q <= pend_d;
      req_q <= req_d;
    end
  end

  // ===========================================
  // sticky event status and interrupt line
  always_comb begin
    ev[ext_irq_pkg::ev_nmi] = hit[ext_irq_pkg::src_nmi];
    ev[ext_irq_pkg::ev_ext] = |hit[ext_irq_pkg::src_external_interrupt_seven:ext_irq_pkg::src_first_external_interrupt];
    ev[ext_irq_pkg::ev_wake] = |hit[ns-1:ext_irq_pkg::src_wake0];
    ev[ext_irq_pkg::ev_clear] = |clr_hit;
    stat_d = stat_q;
    if (bus.wr && bus.addr == ext_irq_pkg::irq_clear_addr) begin
      stat_d = stat_q & ~bus.wdata[3:0];
    end
    stat_d = stat_d | ev;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      stat_q <= 4'h0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // ===========================================
  // read data, one cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        ext_irq_pkg::nmi_watchdog_request_flags_addr: begin
          rdata_d[ext_irq_pkg::nmi_flag_bit] = pend_q[ext_irq_pkg::src_nmi];
          rdata_d[ext_irq_pkg::watchdog_flag_bit] = pend_q[ext_irq_pkg::src_wdt];
        end
        ext_irq_pkg::input_mode_register_addr: rdata_d = mode_q;
        ext_irq_pkg::wake_mode_register_addr: rdata_d = wmode_q;
        ext_irq_pkg::wake_polarity_register_addr: rdata_d = wpol_q;
        ext_irq_pkg::timer_mode_addr: rdata_d = tmode_q;
        ext_irq_pkg::irq_status_addr: rdata_d = {4'h0, stat_q};
        ext_irq_pkg::irq_enable_addr: rdata_d = {4'h0, ien_q};
        ext_irq_pkg::pending_lo_addr: rdata_d = pend_q[7:0];
        ext_irq_pkg::pending_hi_addr: rdata_d = pend_q[15:8];
        default: begin
          for (int i = 0; i < ns; i++) begin
            if (bus.addr == ext_irq_pkg::priority_base_addr + 8'(i)) begin
              rdata_d = {pend_q[i], 4'h0, prio_q[i]};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign irq_req = req_q;
  assign irq_out = |(stat_q & ien_q);

endmodule : ext_irq_ctrl

// *** include/ext_irq_pkg.sv ***
// package with register map, fields and codes of the external interrupt block
//
// Function
// - priority codes 0 and 7 disable, else level
// - nmi falling edge, both edges when set
// - first_external_interrupt rising edge, or high level when set
// - external_interrupt_five falling edge when capture mode is 10
// - external_interrupt_seven falling edge when capture mode is 10
// - wake: both edges, else polarity selects edge
// - eight wake channels with own mode bits
// - nmi/watchdog flags read-only at bits 7,3
// - clear register write clears only named flag
package ext_irq_pkg;

  // ===========================================
  // register offsets
  localparam logic [7:0] nmi_watchdog_request_flags_addr = 8'hf7;
  localparam logic [7:0] interrupt_clear_register_addr = 8'hf8;
  localparam logic [7:0] input_mode_register_addr = 8'hf6;
  localparam logic [7:0] wake_mode_register_addr = 8'hf9;
  localparam logic [7:0] wake_polarity_register_addr = 8'hfa;
  localparam logic [7:0] timer_mode_addr = 8'hfb;
  localparam logic [7:0] priority_base_addr = 8'hd8; // sources 0 to 17 at d8..e9, clear of the f0..fe block
  localparam logic [7:0] irq_status_addr = 8'hfc;
  localparam logic [7:0] irq_enable_addr = 8'hfd;
  localparam logic [7:0] irq_clear_addr = 8'hfe;
  localparam logic [7:0] pending_lo_addr = 8'hf0;
  localparam logic [7:0] pending_hi_addr = 8'hf5;

  // ===========================================
  // field positions and reset values
  localparam int nmi_flag_bit = 7;
  localparam int watchdog_flag_bit = 3;
  localparam int nmi_both_edges_bit = 0;
  localparam int first_external_interrupt_level_mode_bit = 1;
  localparam logic [7:0] reg_reset = 8'h00;
  localparam logic [1:0] capture_falling = 2'b10;
  localparam logic [2:0] prio_off_lo = 3'h0;
  localparam logic [2:0] prio_off_hi = 3'h7;

  // ===========================================
  // source indices, also their clear vector codes offset
  localparam int num_src = 18;
  localparam int src_nmi = 0;
  localparam int src_wdt = 1;
  localparam int src_first_external_interrupt = 2;
  localparam int src_int1 = 3;
  localparam int src_int2 = 4;
  localparam int src_int3 = 5;
  localparam int src_int4 = 6;
  localparam int src_external_interrupt_five = 7;
  localparam int src_int6 = 8;
  localparam int src_external_interrupt_seven = 9;
  localparam int src_wake0 = 10;
  localparam int num_wake = 8;
  localparam int num_ext = 8;
  localparam logic [7:0] vector_base = 8'h08;

  // event kinds for the status register
  localparam int ev_nmi = 0;
  localparam int ev_ext = 1;
  localparam int ev_wake = 2;
  localparam int ev_clear = 3;

  // ===========================================
  // edge selection of one detector
  typedef enum logic [1:0] {
    edge_rise = 2'b00,
    edge_fall = 2'b01,
    edge_both = 2'b10,
    edge_high = 2'b11
  } edge_sel_type;

  // register bus carrier
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  // pending request offered to the cpu
  typedef struct packed {
    logic valid;
    logic [4:0] source;
    logic [2:0] level;
  } irq_req_type;

endpackage : ext_irq_pkg

// *** rtl/edge_detect.sv ***
// one sensing unit: edge or level detection of a pin
module edge_detect (
  input wire logic mclk,
  input wire logic srst,
  input wire logic pin,
  input wire ext_irq_pkg::edge_sel_type sel,
  output logic hit
);

  logic prev_q;
  logic prev_d;

  // ===========================================
  // previous pin value
  always_comb begin
    prev_d = pin;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      prev_q <= prev_d; // start from the pin level, no false edge after reset
    end else begin
      prev_q <= prev_d;
    end
  end

  // ===========================================
  // select the sensing kind
  always_comb begin
    case (sel)
      ext_irq_pkg::edge_rise: hit = pin & ~prev_q;
      ext_irq_pkg::edge_fall: hit = ~pin & prev_q;
      ext_irq_pkg::edge_both: hit = pin ^ prev_q;
      ext_irq_pkg::edge_high: hit = pin;
      default: hit = 1'b0;
    endcase
  end

endmodule : edge_detect

// *** verif/ext_irq_ctrl_properties.sv ***
// port checker of the external interrupt controller
module ext_irq_ctrl_properties (
  input wire logic mclk,
  input wire logic srst,
  input wire ext_irq_pkg::bus_req_type bus,
  input wire logic [7:0] rdata,
  input wire logic irq_accept,
  input wire ext_irq_pkg::irq_req_type irq_req,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================
  // priority mirror
  logic [2:0] prio_q [8];
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // copies priority writes of sources 0 to 7
  always_ff @(posedge mclk) begin
    if (srst) prio_q <= '{default: 3'h0};
    else if (bus.wr && bus.addr[7:3] == 5'h1b) prio_q[bus.addr[2:0]] <= bus.wdata[2:0];
  end
  // ========================================
  // properties
  chk_level_legal: assert property (irq_req.valid |-> irq_req.level inside {[3'h1:3'h6]})
    else $error("disabled level requested");
  chk_level_match: assert property (irq_req.valid && irq_req.source < 5'h08 && !$past(bus.wr)
    && !$past(bus.wr, 2) |-> irq_req.level == prio_q[irq_req.source[2:0]]) else $error("level differs");
  chk_source_range: assert property (irq_req.valid |-> irq_req.source < 5'h12)
    else $error("bad source");
  chk_rdata_idle: assert property (!bus.rd |=> rdata == 8'h00)
    else $error("data without read");
  chk_flag_layout: assert property (bus.rd && bus.addr == 8'hf7 |=> (rdata & 8'h77) == 8'h00)
    else $error("flag bits");
  chk_flag_reset: assert property ($fell(srst) ##0 (bus.rd && bus.addr == 8'hf7) |=> rdata == 8'h00)
    else $error("flags after reset");
  chk_request_hold: assert property (irq_req.valid && !irq_accept && !$past(irq_accept) && !bus.wr
    && !$past(bus.wr) |=> irq_req.valid) else $error("request dropped");
  chk_quiet_reset: assert property ($fell(srst) |-> !irq_out && !irq_req.valid)
    else $error("request after reset");
  cover property (irq_accept);
  cover property (irq_out);
  cover property (bus.rd && bus.addr == 8'hf7 ##1 rdata[7]);
endmodule : ext_irq_ctrl_properties

bind ext_irq_ctrl ext_irq_ctrl_properties chk (.mclk(mclk), .srst(srst), .bus(bus), .rdata(rdata),
  .irq_accept(irq_accept), .irq_req(irq_req), .irq_out(irq_out));

// *** verif/cpu_model.sv ***
// cpu side model: accepts each standing request lag+1 cycles after it appears
module cpu_model (
  input wire logic mclk,
  input wire logic srst,
  input wire ext_irq_pkg::irq_req_type irq_req,
  input wire logic [3:0] lag,
  output logic irq_accept
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  // counts a standing request, one accept pulse at lag
  always_ff @(posedge mclk) begin
    if (srst || !irq_req.valid || irq_accept) begin
      wait_q <= 4'h0;
      irq_accept <= 1'b0;
    end else begin
      wait_q <= wait_q + 4'h1;
      irq_accept <= wait_q == lag;
    end
  end
endmodule : cpu_model

// *** verif/ext_interrupt_mode_and_priority_test.sv ***
// self-checking bench of the external interrupt controller
module ext_interrupt_mode_and_priority_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================
  // stimulus, results and notes
  logic mclk = 1'b0;
  logic srst = 1'b1;
  ext_irq_pkg::bus_req_type bus = '0;
  ext_irq_pkg::irq_req_type irq_req;
  logic [17:0] pins = '0;
  logic [17:0] nxt, hit;
  logic [7:0] rdata;
  logic [7:0] cfg [4];
  logic [15:0] note;
  logic [3:0] lag = 4'h2;
  logic irq_accept, irq_out;
  logic rd_q = 1'b0;
  logic [15:0] rd_exp [$];
  logic [7:0] acc_exp [$];
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int seed = 32'h8f92;
  ext_irq_ctrl dut (.mclk(mclk), .srst(srst), .bus(bus), .rdata(rdata), .nmi_pin(pins[0]),
    .watchdog_interrupt(pins[1]), .ext_pins(pins[9:2]), .wake_pins(pins[17:10]),
    .irq_accept(irq_accept), .irq_req(irq_req), .irq_out(irq_out));
  cpu_model cpu (.mclk(mclk), .srst(srst), .irq_req(irq_req), .lag(lag), .irq_accept(irq_accept));
  // 100 mhz clock
  initial forever #5 mclk = ~mclk;
  // ========================================
  // tasks
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
    check_count++;
    if ((got & msk) !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, got & msk, exp);
    end
  endtask : cmp
  task automatic conclude;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  // one bus cycle, releases reset on first use; e is mask and value
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic r, input logic [15:0] e);
    @(posedge mclk);
    srst <= 1'b0;
    bus <= '{a, d, !r, r};
    if (r) rd_exp.push_back(e);
    @(posedge mclk);
    bus <= '0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, d, 1'b0, 16'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    xfer(a, 8'h00, 1'b1, e);
  endtask : rd
  task automatic clr;
    repeat (2) @(posedge mclk);
    for (int s = 0; s < 18; s++) wr(8'hf8, 8'h08 + 8'(s));
    wr(8'hfe, 8'hff);
  endtask : clr
  task automatic duo(input logic [2:0] a, input logic [2:0] b);
    wr(8'hdb, {5'h0, a});
    wr(8'hdc, {5'h0, b});
    if (b > a) acc_exp.push_back({5'h04, b});
    acc_exp.push_back({5'h03, a});
    if (b <= a) acc_exp.push_back({5'h04, b});
    pins[4:3] <= 2'b11;
    repeat (30) @(posedge mclk);
    pins[4:3] <= 2'b00;
  endtask : duo
  task automatic outchk(input logic e);
    @(negedge mclk);
    cmp({7'h0, irq_out}, {7'h0, e}, 8'h01);
  endtask : outchk
  // expected flag of source i for a pin change o to n
  function automatic logic fires(int i, logic o, logic n);
    logic r, f;
    r = !o && n;
    f = o && !n;
    if (i == 0) return cfg[0][0] ? r | f : f;
    if (i == 2) return cfg[0][1] ? o | n : r;
    if (i == 7) return cfg[3][1:0] == 2'b10 ? f : r;
    if (i == 9) return cfg[3][5:4] == 2'b10 ? f : r;
    if (i > 9) return cfg[1][i-10] ? (cfg[2][i-10] ? r : f) : r | f;
    return r;
  endfunction : fires
  // watcher: oldest note against each answer, and timeout
  always @(posedge mclk) begin
    if (rd_q) begin
      note = rd_exp.pop_front();
      cmp(rdata, note[7:0], note[15:8]);
    end
    if (irq_accept) cmp({irq_req.source, irq_req.level}, acc_exp.size() ? acc_exp.pop_front() : 8'hff, 8'hff);
    rd_q <= bus.rd;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  // ========================================
  // main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rd(8'hf7, 16'hff00);
    rd(8'hf6, 16'hff00);
    wr(8'hf7, 8'hff);
    rd(8'hf7, 16'hff00);
    rd(8'h10, 16'hff00);
    // random modes and pin changes
    for (int k = 0; k < 60; k++) begin
      for (int j = 0; j < 4; j++) begin
        cfg[j] = 8'($random(seed));
        wr(j ? 8'hf8 + 8'(j) : 8'hf6, cfg[j]);
      end
      clr();
      nxt = 18'($random(seed));
      for (int s = 0; s < 18; s++) hit[s] = fires(s, pins[s], nxt[s]);
      @(posedge mclk);
      pins <= nxt;
      repeat (3) @(posedge mclk);
      rd(8'hf0, {8'hff, hit[7:0]});
      rd(8'hf5, {8'hff, hit[15:8]});
      rd(8'hfc, {8'h04, 5'h0, |hit[17:10], 2'h0});
      rd(8'hf7, {8'hff, hit[0], 3'h0, hit[1], 3'h0});
    end
    pins <= '0;
    clr();
    // each priority code on one source, random cpu delays
    for (int c = 0; c < 8; c++) begin
      lag <= 4'h1 + 4'($random(seed) & 7);
      wr(8'hdb, 8'(c));
      if (c % 7) acc_exp.push_back({5'h03, 3'(c)});
      pins[3] <= 1'b1;
      repeat (16) @(posedge mclk);
      rd(8'hdb, {8'h87, c % 7 == 0, 4'h0, 3'(c)});
      wr(8'hf8, 8'h0b);
      rd(8'hdb, 16'h8000);
      pins[3] <= 1'b0;
    end
    duo(3'h2, 3'h5);
    duo(3'h4, 3'h4);
    // masked, enabled and cleared rising edge interrupt
    wr(8'hfe, 8'hff);
    wr(8'hfd, 8'hfd);
    pins[8] <= 1'b1;
    repeat (4) @(posedge mclk);
    outchk(1'b0);
    rd(8'hfc, 16'h0202);
    wr(8'hfd, 8'h02);
    outchk(1'b1);
    wr(8'hfe, 8'h02);
    outchk(1'b0);
    rd(8'hfd, 16'hff02);
    cmp(8'(acc_exp.size()), 8'h00, 8'hff);
    conclude();
  end
endmodule : ext_interrupt_mode_and_priority_test
